// >>> opv_defs.svh
// constants for the otp program/verify port
// assumes inclusion by the mode decoder, the main module and the pulse counter
// How it works
// (R1) signature bytes live at 15-bit locations 030h and 060h, read on data port
// (R2) two signature bytes: maker id then device id
// (R3) programmer keeps the oscillator running 4 to 6 MHz while programming; the bench clock runs at 20 MHz
// (R4) code program takes address 0000h-7fffh, byte and code-program levels
// (R5) a code byte is written after exactly five low strobes
// (R6) every unwritten code byte reads as 00h
// (R7) encryption byte written with 6-bit address after 25 low strobes
// (R8) a 64-entry encryption array, all entries start at 00h
// (R9) verify returns code byte xnor encryption byte chosen by address bits 5:0
// (R10) blank code location verifies as ffh
// (R11) programmer should set a lock bit whenever encryption is used
// (R12) each lock bit programmed by 25 low strobes, no address or data
// (R13) any lock bit set blocks code and encryption programming, not the other lock
// (R14) both lock bits set also disables verify reads
// (R15) verify levels plus address make the device drive the encrypted byte
`ifndef OPV_DEFS_SVH
`define OPV_DEFS_SVH
`define OPV_SIG_MAKER_ADDR  15'h0030
`define OPV_SIG_DEVICE_ADDR 15'h0060
`define OPV_CODE_PULSES     5'h05
`define OPV_LONG_PULSES     5'h19
`define OPV_BLANK_BYTE      8'h00
`define OPV_ZERO_BYTE       8'h00
`define OPV_BLANK_VERIFY    8'hff
`define OPV_COUNT_MAX       5'h1f
`define OPV_PINS_PROG_CODE  5'h0f
`define OPV_PINS_PROG_ENC   5'h0d
`define OPV_PINS_PROG_LOCK1 5'h1f
`define OPV_PINS_PROG_LOCK2 5'h1c
`define OPV_PINS_VERIFY     5'h03
`define OPV_PINS_READ_SIG   5'h00
`endif

// >>> opv_mode_decode.sv
// decodes the control pins into a programming mode
// assumes control pins are synchronous to i_ref_clk
`timescale 1ns/100ps
`include "opv_defs.svh"
module opv_mode_decode
  import opv_pkg::*;
(
  // control levels
  input  wire opv_ctrl_s i_ctrl,
  // decoded mode
  output opv_mode_e      o_mode
);
  always_comb begin
    o_mode = OPV_MODE_IDLE;
    if (i_ctrl.reset_level && !i_ctrl.program_select_pin) begin
      if (i_ctrl.test_enable_vpp_pin) begin
        // high programming voltage present: program modes
        case (i_ctrl.mode_pins)
          `OPV_PINS_PROG_CODE:  o_mode = OPV_MODE_PROG_CODE;
          `OPV_PINS_PROG_ENC:   o_mode = OPV_MODE_PROG_ENC;
          `OPV_PINS_PROG_LOCK1: o_mode = OPV_MODE_PROG_LOCK1;
          `OPV_PINS_PROG_LOCK2: o_mode = OPV_MODE_PROG_LOCK2;
          default: o_mode = OPV_MODE_IDLE;
        endcase
      end else begin
        case (i_ctrl.mode_pins)
          `OPV_PINS_VERIFY:   o_mode = OPV_MODE_VERIFY;
          `OPV_PINS_READ_SIG: o_mode = OPV_MODE_READ_SIG;
          default: o_mode = OPV_MODE_IDLE;
        endcase
      end
    end
  end
endmodule // opv_mode_decode

// >>> opv_otp_port.sv
// otp code memory with encryption array, lock bits, signature and verify
// assumes all pins synchronous to i_ref_clk; memory is modelled as flops
`timescale 1ns/100ps
`include "opv_defs.svh"
module opv_otp_port
  import opv_pkg::*;
#(
  parameter int         ADDR_W    = 15,
  parameter int         ENC_W     = 6,
  parameter logic [7:0] MAKER_ID  = 8'ha5, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3c  // arbitrary value
)
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // address and data ports
  input  wire logic [7:0] i_low_address_port,
  input  wire logic [6:0] i_high_address_port,
  input  wire logic [7:0] i_program_data_port,
  output logic [7:0]      o_program_data_port,
  output logic [7:0]      o_program_data_oe,
  // control pins
  input  wire opv_ctrl_s  i_ctrl,
  input  wire logic       i_strobe_n,
  // status
  output logic            o_lock_bit_one,
  output logic            o_lock_bit_two
);
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int EDEPTH = 1 << ENC_W;

  // ************************************************************
  // mode decode and strobe counting
  // ************************************************************
  opv_mode_e  mode;
  opv_burst_s burst;

  opv_mode_decode u_decode (
    .i_ctrl (i_ctrl),
    .o_mode (mode)
  );

  opv_pulse_count u_count (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_strobe_n (i_strobe_n),
    .i_mode     (mode),
    .o_burst    (burst)
  );

  // ************************************************************
  // address, data capture
  // ************************************************************
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]        wdata_reg, wdata_next;

  always_comb begin
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    if (!i_strobe_n) begin
      // latch while strobe low, stable by setup time
      addr_next  = ADDR_W'({i_high_address_port, i_low_address_port});
      wdata_next = i_program_data_port;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr_reg  <= '0;
      wdata_reg <= `OPV_ZERO_BYTE;
    end else begin
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // ************************************************************
  // lock bits
  // ************************************************************
  logic lock1_reg, lock1_next;
  logic lock2_reg, lock2_next;
  logic locked;
  logic prog_code, prog_enc;

  assign locked = lock1_reg | lock2_reg;

  always_comb begin
    lock1_next = lock1_reg;
    lock2_next = lock2_reg;
    // the other lock bit stays programmable
    if (burst.valid && burst.count == `OPV_LONG_PULSES && burst.mode == OPV_MODE_PROG_LOCK1) begin
      lock1_next = 1'b1; // R12 R13
    end
    if (burst.valid && burst.count == `OPV_LONG_PULSES && burst.mode == OPV_MODE_PROG_LOCK2) begin
      lock2_next = 1'b1; // R12 R13
    end
  end

  // code burst needs exactly five pulses, encryption exactly 25
  assign prog_code = burst.valid && burst.mode == OPV_MODE_PROG_CODE &&
                     burst.count == `OPV_CODE_PULSES && !locked; // R4 R5 R13
  assign prog_enc  = burst.valid && burst.mode == OPV_MODE_PROG_ENC &&
                     burst.count == `OPV_LONG_PULSES && !locked; // R7 R13

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      lock1_reg <= 1'b0;
      lock2_reg <= 1'b0;
    end else begin
      lock1_reg <= lock1_next;
      lock2_reg <= lock2_next;
    end
  end

  // ************************************************************
  // code memory and encryption array
  // ************************************************************
  logic [7:0] code_mem [DEPTH];
  logic [7:0] enc_mem  [EDEPTH];

  // memories start blank; reset restores power-on content in this model
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        code_mem[i] <= `OPV_BLANK_BYTE; // R6
      end
    end else if (prog_code) begin
      code_mem[addr_reg] <= wdata_reg; // R4 R5
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      for (int i = 0; i < EDEPTH; i++) begin
        enc_mem[i] <= `OPV_BLANK_BYTE; // R8
      end
    end else if (prog_enc) begin
      enc_mem[addr_reg[ENC_W-1:0]] <= wdata_reg; // R7 R8
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [ADDR_W-1:0] raddr;
  logic [7:0]        dout_reg, dout_next;
  logic              oe_reg, oe_next;

  assign raddr = ADDR_W'({i_high_address_port, i_low_address_port});

  always_comb begin
    dout_next = `OPV_ZERO_BYTE;
    oe_next   = 1'b0;
    case (mode)
      OPV_MODE_VERIFY: begin
        if (!(lock1_reg && lock2_reg)) begin // R14
          // blank code xnor blank key gives ffh
          dout_next = ~(code_mem[raddr] ^ enc_mem[raddr[ENC_W-1:0]]); // R9 R10 R15
          oe_next   = 1'b1;
        end
      end
      OPV_MODE_READ_SIG: begin
        oe_next = 1'b1;
        if (raddr == `OPV_SIG_MAKER_ADDR) begin
          dout_next = MAKER_ID; // R1 R2
        end else if (raddr == `OPV_SIG_DEVICE_ADDR) begin
          dout_next = DEVICE_ID; // R1 R2
        end
      end
      default: begin
        dout_next = `OPV_ZERO_BYTE;
        oe_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dout_reg <= `OPV_ZERO_BYTE;
      oe_reg   <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg   <= oe_next;
    end
  end

  assign o_program_data_port = dout_reg;
  assign o_program_data_oe   = {8{oe_reg}};
  assign o_lock_bit_one      = lock1_reg;
  assign o_lock_bit_two      = lock2_reg;

  // ************************************************************
  // checks: programming
  // ************************************************************
  AST_CODE_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R5
    prog_code |=> code_mem[$past(addr_reg)] == $past(wdata_reg))
    else $error("code byte not stored");

  AST_ENC_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R7
    prog_enc |=> enc_mem[$past(addr_reg[ENC_W-1:0])] == $past(wdata_reg))
    else $error("key byte not stored");

  AST_CODE_COUNT: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R5
    (burst.valid && burst.mode == OPV_MODE_PROG_CODE && burst.count != `OPV_CODE_PULSES)
    |=> code_mem[$past(addr_reg)] == $past(code_mem[addr_reg]))
    else $error("code byte stored after wrong pulse count");

  AST_ENC_COUNT: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R7
    (burst.valid && burst.mode == OPV_MODE_PROG_ENC && burst.count != `OPV_LONG_PULSES)
    |=> enc_mem[$past(addr_reg[ENC_W-1:0])] == $past(enc_mem[addr_reg[ENC_W-1:0]]))
    else $error("key byte stored after wrong pulse count");

  AST_CODE_LOCKED: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R13
    (burst.valid && burst.mode == OPV_MODE_PROG_CODE && locked)
    |=> code_mem[$past(addr_reg)] == $past(code_mem[addr_reg]))
    else $error("code byte changed while locked");

  AST_ENC_LOCKED: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R13
    (burst.valid && burst.mode == OPV_MODE_PROG_ENC && locked)
    |=> enc_mem[$past(addr_reg[ENC_W-1:0])] == $past(enc_mem[addr_reg[ENC_W-1:0]]))
    else $error("key byte changed while locked");

  // ************************************************************
  // checks: lock bits
  // ************************************************************
  AST_LOCK1_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    (burst.valid && burst.mode == OPV_MODE_PROG_LOCK1 && burst.count == `OPV_LONG_PULSES) |=> lock1_reg)
    else $error("lock bit one not set");

  AST_LOCK2_SET: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    (burst.valid && burst.mode == OPV_MODE_PROG_LOCK2 && burst.count == `OPV_LONG_PULSES) |=> lock2_reg)
    else $error("lock bit two not set");

  AST_LOCK_SHORT: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    (burst.valid && burst.mode == OPV_MODE_PROG_LOCK1 && burst.count != `OPV_LONG_PULSES && !lock1_reg)
    |=> !lock1_reg)
    else $error("lock bit one set by wrong pulse count");

  AST_OTHER_LOCK: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R13
    (lock1_reg && !lock2_reg && burst.valid && burst.mode == OPV_MODE_PROG_LOCK2 &&
     burst.count == `OPV_LONG_PULSES) |=> lock2_reg)
    else $error("second lock bit refused");

  AST_LOCK_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    lock1_reg |=> lock1_reg)
    else $error("lock bit one cleared");

  AST_LOCK2_STICKY: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    lock2_reg |=> lock2_reg)
    else $error("lock bit two cleared");

  AST_LOCK_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R12
    !burst.valid |=> $stable(lock1_reg) && $stable(lock2_reg))
    else $error("lock bit moved without a burst");

  // ************************************************************
  // checks: read path
  // ************************************************************
  AST_CODE_BLANK_RESET: assert property (@(posedge i_ref_clk) // R6
    i_reset |=> code_mem[raddr] == `OPV_BLANK_BYTE)
    else $error("code byte not blank after reset");

  AST_ENC_BLANK_RESET: assert property (@(posedge i_ref_clk) // R8
    i_reset |=> enc_mem[raddr[ENC_W-1:0]] == `OPV_BLANK_BYTE)
    else $error("key byte not blank after reset");

  AST_BLANK_VERIFY: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R10
    (mode == OPV_MODE_VERIFY && !(lock1_reg && lock2_reg) && code_mem[raddr] == `OPV_BLANK_BYTE &&
     enc_mem[raddr[ENC_W-1:0]] == `OPV_BLANK_BYTE) |=> dout_reg == `OPV_BLANK_VERIFY)
    else $error("blank location did not verify as all ones");

  AST_XNOR: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R9
    (mode == OPV_MODE_VERIFY && !(lock1_reg && lock2_reg))
    |=> dout_reg == ~($past(code_mem[raddr]) ^ $past(enc_mem[raddr[ENC_W-1:0]])))
    else $error("verify byte not xnor");

  AST_VERIFY_DRIVES: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R15
    (mode == OPV_MODE_VERIFY && !(lock1_reg && lock2_reg)) |=> oe_reg)
    else $error("verify did not drive data");

  AST_FULL_LOCK_NO_VERIFY: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R14
    (mode == OPV_MODE_VERIFY && lock1_reg && lock2_reg) |=> !oe_reg && dout_reg == `OPV_ZERO_BYTE)
    else $error("verify driven with both locks");

  AST_IDLE_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R15
    (mode != OPV_MODE_VERIFY && mode != OPV_MODE_READ_SIG) |=> !oe_reg && dout_reg == `OPV_ZERO_BYTE)
    else $error("data driven outside read modes");

  AST_SIG_MAKER: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
    (mode == OPV_MODE_READ_SIG && raddr == `OPV_SIG_MAKER_ADDR) |=> dout_reg == MAKER_ID)
    else $error("maker signature wrong");

  AST_SIG_DEVICE: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R2
    (mode == OPV_MODE_READ_SIG && raddr == `OPV_SIG_DEVICE_ADDR) |=> dout_reg == DEVICE_ID)
    else $error("device signature wrong");

  AST_SIG_DRIVES: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
    (mode == OPV_MODE_READ_SIG) |=> oe_reg)
    else $error("signature read did not drive data");

  AST_SIG_UNMAPPED: assert property (@(posedge i_ref_clk) disable iff (i_reset) // R1
    (mode == OPV_MODE_READ_SIG && raddr != `OPV_SIG_MAKER_ADDR && raddr != `OPV_SIG_DEVICE_ADDR)
    |=> dout_reg == `OPV_ZERO_BYTE)
    else $error("unmapped signature location not zero");
endmodule // opv_otp_port

// >>> opv_pkg.sv
// types for the otp program/verify port
// assumes opv_defs.svh is on the include path
package opv_pkg;
  // mode decoded from the control pins
  typedef enum logic [2:0] {
    OPV_MODE_IDLE,
    OPV_MODE_PROG_CODE,
    OPV_MODE_VERIFY,
    OPV_MODE_PROG_ENC,
    OPV_MODE_PROG_LOCK1,
    OPV_MODE_PROG_LOCK2,
    OPV_MODE_READ_SIG
  } opv_mode_e;

  // levels on the control pins besides the strobe
  typedef struct packed {
    logic       reset_level;
    logic       program_select_pin;
    logic       test_enable_vpp_pin;
    logic [4:0] mode_pins;
  } opv_ctrl_s;

  // outcome of one finished strobe burst
  typedef struct packed {
    logic      valid;
    opv_mode_e mode;
    logic [4:0] count;
  } opv_burst_s;
endpackage : opv_pkg

// >>> opv_pulse_count.sv
// counts low strobe pulses while one mode holds, reports the burst when it ends
// assumes strobe is synchronous and idles high
`timescale 1ns/100ps
`include "opv_defs.svh"
module opv_pulse_count
  import opv_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  // strobe and mode
  input  wire logic       i_strobe_n,
  input  wire opv_mode_e  i_mode,
  // finished burst
  output opv_burst_s      o_burst
);
  logic       strobe_d_reg, strobe_d_next;
  opv_mode_e  mode_reg, mode_next;
  logic [4:0] count_reg, count_next;
  opv_burst_s burst_reg, burst_next;

  always_comb begin
    strobe_d_next = i_strobe_n;
    mode_next     = i_mode;
    count_next    = count_reg;
    burst_next    = '{valid: 1'b0, mode: mode_reg, count: count_reg};
    if (i_mode != mode_reg) begin
      // mode change ends the burst
      burst_next.valid = (count_reg != 5'h00);
      count_next       = 5'h00;
    end else if (strobe_d_reg && !i_strobe_n && count_reg != `OPV_COUNT_MAX) begin
      count_next = count_reg + 5'h01;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      strobe_d_reg <= 1'b1;
      mode_reg     <= OPV_MODE_IDLE;
      count_reg    <= 5'h00;
      burst_reg    <= '{valid: 1'b0, mode: OPV_MODE_IDLE, count: 5'h00};
    end else begin
      strobe_d_reg <= strobe_d_next;
      mode_reg     <= mode_next;
      count_reg    <= count_next;
      burst_reg    <= burst_next;
    end
  end

  assign o_burst = burst_reg;
endmodule // opv_pulse_count

// >>> opv_rom_writer.sv
// model of the external rom writer that drives the program/verify pins
// assumes the bench supplies the clock and calls burst and read in turn
`timescale 1ns/100ps
module opv_rom_writer
  import opv_pkg::*;
(
  // clock
  input  wire logic       i_ref_clk,
  // pins toward the device
  output logic [7:0]      o_low_address_port,
  output logic [6:0]      o_high_address_port,
  output logic [7:0]      o_program_data_port,
  output opv_ctrl_s       o_ctrl,
  output logic            o_strobe_n,
  // data returned by the device
  input  wire logic [7:0] i_program_data_port
);
  initial begin
    o_low_address_port  = 8'h00;
    o_high_address_port = 7'h00;
    o_program_data_port = 8'h00;
    o_ctrl              = '0;
    o_strobe_n          = 1'b1;
  end

  // one strobe burst under fixed mode levels, then idle to commit
  task automatic burst(input logic vpp, input logic [4:0] mode, input logic [14:0] addr,
                       input logic [7:0] data, input int n);
    @(negedge i_ref_clk);
    o_ctrl = '{1'b1, 1'b0, vpp, mode};
    {o_high_address_port, o_low_address_port} = addr;
    o_program_data_port = data;
    repeat (n) begin
      @(negedge i_ref_clk) o_strobe_n = 1'b0;
      @(negedge i_ref_clk) o_strobe_n = 1'b1;
    end
    @(negedge i_ref_clk);
    o_ctrl = '0;
    // released data line shows a changed value, not the old one
    o_program_data_port = ~data;
    repeat (3) @(negedge i_ref_clk);
  endtask

  // read under verify or signature levels, sampled once settled
  task automatic read(input logic [4:0] mode, input logic [14:0] addr, output logic [7:0] data);
    @(negedge i_ref_clk);
    o_ctrl = '{1'b1, 1'b0, 1'b0, mode};
    {o_high_address_port, o_low_address_port} = addr;
    o_program_data_port = ~o_program_data_port;
    repeat (2) @(negedge i_ref_clk);
    data = i_program_data_port;
  endtask
endmodule // opv_rom_writer

// >>> otp_program_verify_port_tb_top.sv
// self-checking bench for the otp program/verify port
// assumes opv_pkg, opv_defs.svh and the writer model are compiled first
`timescale 1ns/100ps
module otp_program_verify_port_tb_top;
  import opv_pkg::*;
  localparam logic [7:0] MAKER  = 8'h96; // arbitrary value
  localparam logic [7:0] DEVICE = 8'h4b; // arbitrary value
  logic       clk;
  logic       rst;
  logic [7:0] lo;
  logic [6:0] hi;
  logic [7:0] din;
  logic [7:0] dout;
  logic [7:0] oe;
  opv_ctrl_s  ctrl;
  logic       stb_n;
  logic       lb1;
  logic       lb2;
  logic [7:0] rd;
  int         n_errors    = 0;
  int         check_count = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  opv_otp_port #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) u_dut (
    .i_ref_clk(clk), .i_reset(rst), .i_low_address_port(lo), .i_high_address_port(hi),
    .i_program_data_port(din), .o_program_data_port(dout), .o_program_data_oe(oe),
    .i_ctrl(ctrl), .i_strobe_n(stb_n), .o_lock_bit_one(lb1), .o_lock_bit_two(lb2));

  opv_rom_writer u_prog (
    .i_ref_clk(clk), .o_low_address_port(lo), .o_high_address_port(hi),
    .o_program_data_port(din), .o_ctrl(ctrl), .o_strobe_n(stb_n), .i_program_data_port(dout));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // verify read: data and drive enable
  task automatic vfy(input logic [14:0] a, input logic [7:0] exp, input logic [7:0] exp_oe);
    u_prog.read(5'h03, a, rd);
    chk(rd, exp);
    chk(oe, exp_oe);
  endtask

  task automatic locks(input logic [1:0] exp);
    chk({6'h00, lb2, lb1}, {6'h00, exp});
  endtask

  initial begin
    #200000;
    n_errors++;
    results;
  end

  initial begin
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    locks(2'b00);
    vfy(15'h1234, 8'hff, 8'hff);
    u_prog.read(5'h00, 15'h0030, rd);
    chk(rd, MAKER);
    u_prog.read(5'h00, 15'h0060, rd);
    chk(rd, DEVICE);
    u_prog.read(5'h00, 15'h0031, rd);
    chk(rd, 8'h00);
    chk(oe, 8'hff);
    u_prog.burst(1'b1, 5'h0f, 15'h7fff, 8'h5a, 5);
    vfy(15'h7fff, 8'ha5, 8'hff);
    u_prog.burst(1'b1, 5'h0f, 15'h0000, 8'hc3, 5);
    vfy(15'h0000, 8'h3c, 8'hff);
    for (int n = 4; n <= 6; n += 2) begin
      u_prog.burst(1'b1, 5'h0f, 15'h0100, 8'h77, n);
      vfy(15'h0100, 8'hff, 8'hff);
    end
    u_prog.burst(1'b1, 5'h0d, 15'h003f, 8'h0f, 24);
    vfy(15'h7fff, 8'ha5, 8'hff);
    u_prog.burst(1'b1, 5'h0d, 15'h003f, 8'h0f, 25);
    vfy(15'h7fff, 8'haa, 8'hff);
    vfy(15'h003f, 8'hf0, 8'hff);
    u_prog.burst(1'b1, 5'h0d, 15'h00c1, 8'h33, 25);
    vfy(15'h0001, 8'hcc, 8'hff);
    u_prog.burst(1'b1, 5'h1f, 15'h0000, 8'h00, 24);
    locks(2'b00);
    u_prog.burst(1'b1, 5'h1f, 15'h0000, 8'h00, 25);
    locks(2'b01);
    u_prog.burst(1'b1, 5'h0f, 15'h0200, 8'h11, 5);
    vfy(15'h0200, 8'hff, 8'hff);
    u_prog.burst(1'b1, 5'h0d, 15'h003f, 8'hff, 25);
    vfy(15'h7fff, 8'haa, 8'hff);
    u_prog.burst(1'b1, 5'h1c, 15'h0000, 8'h00, 25);
    locks(2'b11);
    vfy(15'h7fff, 8'h00, 8'h00);
    results;
  end
endmodule // otp_program_verify_port_tb_top
